// File: design/report_link_pkg.sv
package report_link_pkg;
  localparam logic [4:0]  DEV_ADDR      = 5'h00;
  localparam logic [2:0]  OP_DIAG_READ  = 3'h4;
  localparam logic [2:0]  OP_REPORT_RDY = 3'h5;
  localparam logic [2:0]  OP_IDLE_LOAD  = 3'h6;
  localparam logic [2:0]  OP_DATA_LOAD  = 3'h7;
  localparam logic [7:0]  CMD_NONE      = 8'hFF;
  localparam int          Y_LAG         = 2;
  localparam int          TX_DIV        = 8;
  localparam logic [2:0]  TX_RISE_CNT   = 3'h3;
  localparam logic [2:0]  TX_FALL_CNT   = 3'h7;
  localparam int          BUF_DEPTH     = 16;
  localparam logic [3:0]  ONES_PRESET   = 4'hA;
  localparam logic [3:0]  ONES_CARRY    = 4'hF;
  localparam logic [15:0] CRC_POLY      = 16'h1021;
  localparam logic [15:0] CRC_INIT      = 16'h0000;
  localparam logic [7:0]  IDLE_RESET    = 8'h7E;
  localparam logic [7:0]  OFS_IDLE      = 8'h00;
  localparam logic [7:0]  OFS_WORD      = 8'h04;
  localparam logic [7:0]  OFS_CTRL      = 8'h08;
  localparam logic [7:0]  OFS_STATUS    = 8'h0C;
  localparam logic [7:0]  OFS_DIAG      = 8'h10;
  localparam int          CTRL_SEND     = 0;
  localparam int          CTRL_DIAG_EN  = 1;
  localparam int          CTRL_DIAG_RD  = 2;

  function automatic logic is_cmd(input logic [7:0] cmd, input logic [2:0] op);
    return (cmd[7:3] == DEV_ADDR) && (cmd[2:0] == op);
  endfunction : is_cmd

  function automatic logic [7:0] make_cmd(input logic [2:0] op);
    return {DEV_ADDR, op};
  endfunction : make_cmd
endpackage : report_link_pkg

// File: design/report_link_if.sv
`timescale 1ns/1ps
interface report_link_if;
  logic [7:0]  cmd;
  logic [15:0] ybus;
  logic [15:0] diag_word;
  logic        diag_valid;
  logic        tx_line;
  logic        tx_clock;
  logic        gated_tx_clock;
  logic        message_idle_select;

  modport dev (input cmd, input ybus, output diag_word, output diag_valid, output tx_line,
               output tx_clock, output gated_tx_clock, output message_idle_select);
  modport ctl (output cmd, output ybus, input diag_word, input diag_valid, input tx_line,
               input tx_clock, input gated_tx_clock, input message_idle_select);
endinterface : report_link_if

// File: design/crc16_serial.sv
`timescale 1ns/1ps
module crc16_serial
  import report_link_pkg::*;
(
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic ce,
  input  wire logic clr,
  input  wire logic step,
  input  wire logic check_word_enable,
  input  wire logic din,
  output logic      msb
);
  logic [15:0] crc_q;
  logic [15:0] crc_d;
  wire         fb = crc_q[15] ^ din;

  // Top bit steers the feedback taps while data enters, then the register shifts out
  assign crc_d = check_word_enable ? ({crc_q[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000))
                                   : {crc_q[14:0], 1'b0};
  assign msb   = crc_q[15];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) crc_q <= CRC_INIT;
    else if (ce && clr) crc_q <= CRC_INIT;
    else if (ce && step) crc_q <= crc_d;
  end
endmodule : crc16_serial

// File: design/report_tx_framer.sv
`timescale 1ns/1ps
module report_tx_framer
  import report_link_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   sys_rst,
  input  wire logic   ce,
  input  wire logic   diag_mode,
  report_link_if.dev  link,
  output logic        report_pending,
  output logic        data_check_select,
  output logic        check_word_enable,
  output logic        shift_load_select,
  output logic        stuff_skip_n,
  output logic        buffer_write_strobe
);
  typedef enum logic [1:0] {ST_IDLE, ST_DATA, ST_CHECK, ST_END} tx_state_e;

  tx_state_e   state_q;
  logic [2:0]  div_q;
  logic        tx_clk_q;
  logic        gated_q;
  logic        skip_q;
  logic [1:0]  idle_pipe_q;
  logic        idle_flag_q;
  logic [7:0]  idle_reg_q;
  logic [7:0]  idle_sh_q;
  logic [2:0]  idle_bit_q;
  logic        load_prev_q;
  logic        lead_dly_q;
  logic        trail_dly_q;
  logic        load_active_q;
  logic [15:0] buf_mem [BUF_DEPTH];
  logic [4:0]  wr_ptr_q;
  logic [4:0]  rd_ptr_q;
  logic [15:0] data_sh_q;
  logic [3:0]  bit_cnt_q;
  logic [3:0]  ones_q;
  logic        msg_sel_q;
  logic        dcs_q;
  logic        cwe_q;
  logic        ready_q;
  logic        crc_step_q;
  logic        crc_clr_q;
  logic        tx_line_q;
  logic [15:0] loop_q;
  logic [15:0] diag_q;
  logic        diag_valid_q;
  logic        slsel_q;
  logic        wstrobe_q;
  logic        crc_msb;

  wire cmd_idle  = is_cmd(link.cmd, OP_IDLE_LOAD);
  wire cmd_load  = is_cmd(link.cmd, OP_DATA_LOAD);
  wire cmd_go    = is_cmd(link.cmd, OP_REPORT_RDY);
  wire cmd_diag  = is_cmd(link.cmd, OP_DIAG_READ);
  wire lead      = cmd_load & ~load_prev_q;
  wire trail     = ~cmd_load & load_prev_q;
  wire rise      = ce && (div_q == TX_RISE_CNT);
  wire fall      = ce && (div_q == TX_FALL_CNT);
  wire carry     = (ones_q == ONES_CARRY);
  wire tick      = rise && !carry;
  wire buf_empty = (wr_ptr_q == rd_ptr_q);
  wire [2:0] div_d   = div_q + 3'h1;
  wire       idle_ld = ~idle_pipe_q[1];
  wire       at_idle = (state_q == ST_IDLE) || (state_q == ST_END);
  wire       last_bit = (bit_cnt_q == 4'hF);
  wire       start   = (state_q == ST_IDLE) && ready_q && !buf_empty && (idle_bit_q == 3'h7);
  wire       out_bit = (state_q == ST_DATA)  ? data_sh_q[15] :
                       (state_q == ST_CHECK) ? crc_msb : idle_sh_q[7];

  assign report_pending      = ready_q;
  assign data_check_select   = dcs_q;
  assign check_word_enable   = cwe_q;
  assign shift_load_select   = slsel_q;
  assign stuff_skip_n        = ~skip_q;
  assign buffer_write_strobe = wstrobe_q;
  assign link.tx_line             = tx_line_q;
  assign link.tx_clock            = tx_clk_q;
  assign link.gated_tx_clock      = gated_q;
  assign link.message_idle_select = msg_sel_q;
  assign link.diag_word           = diag_q;
  assign link.diag_valid          = diag_valid_q;

  crc16_serial u_crc (
    .clk               (clk),
    .sys_rst           (sys_rst),
    .ce                (ce),
    .clr               (crc_clr_q),
    .step              (fall && crc_step_q),
    .check_word_enable (cwe_q),
    .din               (tx_line_q),
    .msb               (crc_msb)
  );

  // Divide by eight, 50 percent duty; the gated copy loses its high phase on a skip
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_q    <= 3'h0;
      tx_clk_q <= 1'b0;
      gated_q  <= 1'b0;
      skip_q   <= 1'b0;
    end else if (ce) begin
      div_q    <= div_d;
      tx_clk_q <= div_d[2];
      if (rise) skip_q <= carry;
      gated_q  <= div_d[2] & ~(rise ? carry : skip_q);
    end
  end

  // Command side: idle byte and data load sequencing on the system clock
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      idle_pipe_q   <= 2'b00;
      idle_flag_q   <= 1'b0;
      idle_reg_q    <= IDLE_RESET;
      load_prev_q   <= 1'b0;
      lead_dly_q    <= 1'b0;
      trail_dly_q   <= 1'b0;
      load_active_q <= 1'b0;
      wr_ptr_q      <= 5'h00;
      wstrobe_q     <= 1'b0;
      ready_q       <= 1'b0;
      diag_q        <= 16'h0000;
      diag_valid_q  <= 1'b0;
    end else if (ce) begin
      idle_pipe_q <= {idle_pipe_q[0], cmd_idle};
      if (!idle_ld) idle_reg_q <= link.ybus[7:0];
      // Set wins over the clear; cleared as the select drops so the load lasts one bit
      if (!idle_ld) idle_flag_q <= 1'b1;
      else if (tick && slsel_q) idle_flag_q <= 1'b0;
      load_prev_q <= cmd_load;
      lead_dly_q  <= lead;
      // Trailing edge lags as the leading one does, so the last word is still written
      trail_dly_q <= trail;
      if (lead_dly_q) load_active_q <= 1'b1;
      else if (trail_dly_q) load_active_q <= 1'b0;
      wstrobe_q <= load_active_q;
      if (load_active_q) begin
        buf_mem[wr_ptr_q[3:0]] <= link.ybus;
        wr_ptr_q <= wr_ptr_q + 5'h01;
      end
      if (cmd_go) ready_q <= 1'b1;
      else if (tick && state_q == ST_END) ready_q <= 1'b0;
      diag_valid_q <= cmd_diag && diag_mode;
      if (cmd_diag && diag_mode) diag_q <= loop_q;
    end
  end

  // Transmit side: every step below except the crc_clr_q clear happens only on a rising transmit edge
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q    <= ST_IDLE;
      slsel_q    <= 1'b1;
      idle_sh_q  <= IDLE_RESET;
      idle_bit_q <= 3'h0;
      rd_ptr_q   <= 5'h00;
      data_sh_q  <= 16'h0000;
      bit_cnt_q  <= 4'h0;
      ones_q     <= ONES_PRESET;
      msg_sel_q  <= 1'b0;
      dcs_q      <= 1'b1;
      cwe_q      <= 1'b1;
      crc_step_q <= 1'b0;
      crc_clr_q  <= 1'b0;
      tx_line_q  <= 1'b1;
      loop_q     <= 16'h0000;
    end else if (ce) begin
      crc_clr_q <= 1'b0;
      if (rise && carry) begin
        tx_line_q  <= 1'b0;
        ones_q     <= ONES_PRESET;
        crc_step_q <= 1'b0;
        loop_q     <= {loop_q[14:0], 1'b0};
      end else if (tick) begin
        tx_line_q <= out_bit;
        loop_q    <= {loop_q[14:0], out_bit};
        slsel_q   <= ~idle_flag_q;
        // The closing idle slot must not arm a stuff after the select drops
        if (!msg_sel_q || state_q == ST_END) ones_q <= ONES_PRESET;
        else if (out_bit) ones_q <= ones_q + 4'h1;
        else ones_q <= ONES_PRESET;
        crc_step_q <= (state_q == ST_DATA) || (state_q == ST_CHECK);
        if (at_idle) begin
          idle_bit_q <= idle_bit_q + 3'h1;
          if (!slsel_q) idle_sh_q <= idle_reg_q;
          else idle_sh_q <= {idle_sh_q[6:0], idle_sh_q[7]};
        end
        case (state_q)
          ST_IDLE: begin
            if (start) begin
              data_sh_q <= buf_mem[rd_ptr_q[3:0]];
              rd_ptr_q  <= rd_ptr_q + 5'h01;
              bit_cnt_q <= 4'h0;
              msg_sel_q <= 1'b1;
              dcs_q     <= 1'b1;
              cwe_q     <= 1'b1;
              crc_clr_q <= 1'b1;
              state_q   <= ST_DATA;
            end
          end
          ST_DATA: begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
            data_sh_q <= {data_sh_q[14:0], 1'b0};
            if (last_bit && buf_empty) begin
              dcs_q   <= 1'b0;
              state_q <= ST_CHECK;
            end else if (last_bit) begin
              data_sh_q <= buf_mem[rd_ptr_q[3:0]];
              rd_ptr_q  <= rd_ptr_q + 5'h01;
            end
          end
          ST_CHECK: begin
            // Drops with the first check bit: the last data bit still needs feedback
            cwe_q     <= 1'b0;
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (last_bit) state_q <= ST_END;
          end
          default: begin
            // Stays in the message until any last stuffed zero has gone out
            msg_sel_q  <= 1'b0;
            dcs_q      <= 1'b1;
            cwe_q      <= 1'b1;
            idle_bit_q <= 3'h0;
            state_q    <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule : report_tx_framer

// File: design/report_ctl_end.sv
`timescale 1ns/1ps
module report_ctl_end
  import report_link_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   sys_rst,
  input  wire logic   ce,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata,
  output logic             diag_mode,
  report_link_if.ctl  link
);
  typedef enum logic [1:0] {C_IDLE, C_BYTE, C_LOAD, C_GO} ctl_state_e;

  ctl_state_e  state_q;
  logic [15:0] mem [BUF_DEPTH];
  logic [4:0]  count_q;
  logic [4:0]  cyc_q;
  logic [7:0]  cmd_q;
  logic [15:0] y_q;
  logic [15:0] diag_q;
  logic        diag_en_q;
  logic [31:0] rdata_q;

  wire        busy    = (state_q != C_IDLE);
  wire        wr_idle = wr && !busy && (addr == OFS_IDLE);
  wire        wr_word = wr && !busy && (addr == OFS_WORD) && (count_q < 5'(BUF_DEPTH));
  wire        wr_ctrl = wr && !busy && (addr == OFS_CTRL);
  wire        do_send = wr_ctrl && wdata[CTRL_SEND] && (count_q != 5'h00);
  wire        do_diag = wr_ctrl && wdata[CTRL_DIAG_RD] && diag_en_q;
  wire [4:0]  widx    = cyc_q - 5'(Y_LAG);
  wire [31:0] status  = {25'h0000000, link.message_idle_select, busy, count_q};
  wire [31:0] rd_mux  = (addr == OFS_STATUS) ? status :
                        (addr == OFS_DIAG)   ? {16'h0000, diag_q} :
                        (addr == OFS_CTRL)   ? {30'h0, diag_en_q, 1'b0} : 32'h0;

  assign link.cmd  = cmd_q;
  assign link.ybus = y_q;
  assign rdata     = rdata_q;
  assign diag_mode = diag_en_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q   <= C_IDLE;
      count_q   <= 5'h00;
      cyc_q     <= 5'h00;
      cmd_q     <= CMD_NONE;
      y_q       <= 16'h0000;
      diag_q    <= 16'h0000;
      diag_en_q <= 1'b0;
      rdata_q   <= 32'h0;
    end else if (ce) begin
      rdata_q <= rd ? rd_mux : 32'h0;
      if (wr_ctrl) diag_en_q <= wdata[CTRL_DIAG_EN];
      if (link.diag_valid) diag_q <= link.diag_word;
      if (wr_word) begin
        mem[count_q[3:0]] <= wdata[15:0];
        count_q <= count_q + 5'h01;
      end
      cmd_q <= CMD_NONE;
      case (state_q)
        C_IDLE: begin
          cyc_q <= 5'h00;
          if (wr_idle) begin
            cmd_q   <= make_cmd(OP_IDLE_LOAD);
            y_q     <= {8'h00, wdata[7:0]};
            state_q <= C_BYTE;
          end else if (do_send) begin
            cmd_q   <= make_cmd(OP_DATA_LOAD);
            state_q <= C_LOAD;
            cyc_q   <= 5'h01;
          end else if (do_diag) cmd_q <= make_cmd(OP_DIAG_READ);
        end
        C_BYTE: begin
          // Byte held so it is still on the bus when the delayed load pulse arrives
          cyc_q <= cyc_q + 5'h01;
          if (cyc_q == 5'(Y_LAG - 1)) state_q <= C_IDLE;
        end
        C_LOAD: begin
          cyc_q <= cyc_q + 5'h01;
          if (cyc_q < count_q) cmd_q <= make_cmd(OP_DATA_LOAD);
          if (cyc_q >= 5'(Y_LAG)) y_q <= mem[widx[3:0]];
          if (cyc_q == count_q + 5'(Y_LAG) - 5'h01) state_q <= C_GO;
        end
        default: begin
          cmd_q   <= make_cmd(OP_REPORT_RDY);
          count_q <= 5'h00;
          state_q <= C_IDLE;
        end
      endcase
    end
  end
endmodule : report_ctl_end

// File: sim/report_link_asserts.sv
`timescale 1ns/1ps
module report_link_asserts (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic [7:0] cmd,
  input wire logic       diag_valid,
  input wire logic       tx_line,
  input wire logic       tx_clock,
  input wire logic       gated_tx_clock,
  input wire logic       message_idle_select,
  input wire logic       diag_mode,
  input wire logic       report_pending,
  input wire logic       data_check_select,
  input wire logic       check_word_enable,
  input wire logic       shift_load_select,
  input wire logic       stuff_skip_n,
  input wire logic       buffer_write_strobe
);
  logic [3:0] run_q;
  logic       tx_p_q;
  logic       ms_r_q;
  // Line sampled one system clock after transmit rise, when it holds the bit launched at that rise
  wire        tx_rise = tx_clock && !tx_p_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_q  <= 4'h0;
      tx_p_q <= 1'b0;
      ms_r_q <= 1'b0;
    end else begin
      tx_p_q <= tx_clock;
      // The slot in which the select rises still carries an idle bit
      if (tx_rise) ms_r_q <= message_idle_select;
      if (!message_idle_select) run_q <= 4'h0;
      else if (tx_rise) run_q <= (tx_line && ms_r_q) ? run_q + 4'h1 : 4'h0;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence load_lead; cmd == 8'h07 && $past(cmd) != 8'h07; endsequence
  sequence load_trail; cmd != 8'h07 && $past(cmd) == 8'h07; endsequence
  sequence skip_slot; (!stuff_skip_n)[*8] ##1 stuff_skip_n; endsequence
  sequence idle_copy; (!shift_load_select)[*8] ##1 shift_load_select; endsequence

  chk_tx_divide: assert property ($rose(tx_clock) |-> tx_clock[*4] ##1 (!tx_clock)[*4])
    else $error("transmit clock not an eight cycle square wave");
  chk_gated_inside: assert property (gated_tx_clock |-> tx_clock)
    else $error("gated clock high outside transmit clock high");
  chk_skip_msg: assert property (!stuff_skip_n |-> message_idle_select)
    else $error("zero insertion outside a message");
  chk_skip_width: assert property ($fell(stuff_skip_n) |-> skip_slot)
    else $error("skip not one transmit bit long");
  chk_skip_zero: assert property ($fell(stuff_skip_n) |-> ##2 (!tx_line)[*4])
    else $error("skip slot not a zero on the line");
  chk_no_six: assert property (run_q <= 4'h5)
    else $error("six ones in a row inside a message");
  chk_load_start: assert property (load_lead |-> ##2 !buffer_write_strobe ##1 buffer_write_strobe)
    else $error("write strobes start at wrong cycle");
  chk_load_end: assert property (load_trail |-> ##2 buffer_write_strobe ##1 !buffer_write_strobe)
    else $error("write strobes stop at wrong cycle");
  chk_go_pending: assert property (cmd == 8'h05 |=> report_pending)
    else $error("ready command did not set pending");
  chk_diag_answer: assert property (cmd == 8'h04 |=> diag_valid == diag_mode)
    else $error("diagnostic answer does not follow mode");
  chk_diag_cause: assert property (diag_valid |-> $past(cmd) == 8'h04)
    else $error("diagnostic answer without read command");
  chk_idle_req: assert property (cmd == 8'h06 |-> ##[3:40] $fell(shift_load_select))
    else $error("idle load never reached shift register");
  chk_idle_copy: assert property ($fell(shift_load_select) |-> idle_copy)
    else $error("load select not low for one transmit bit");
  chk_check_field: assert property (!data_check_select |-> message_idle_select)
    else $error("check field outside a message");
  chk_cwe_data: assert property (data_check_select |-> check_word_enable)
    else $error("check enable low while data selected");
  chk_gated_skip: assert property ($fell(stuff_skip_n) |-> (!gated_tx_clock)[*4])
    else $error("gated clock not held low in skip slot");
  chk_gated_follow: assert property (stuff_skip_n |-> gated_tx_clock == tx_clock)
    else $error("gated clock differs outside skip");
endmodule : report_link_asserts

// File: sim/report_link_tx_framing_tb_top.sv
`timescale 1ns/1ps
module report_link_tx_framing_tb_top;
  import report_link_pkg::*;
  logic        clk, sys_rst, wr, rd, chk_q, chk_d_q, tx_p_q, ms_p_q;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata;
  logic        diag_mode, report_pending, data_check_select, check_word_enable;
  logic        shift_load_select, stuff_skip_n, buffer_write_strobe;
  int          n_errors = 0;
  int          compares = 0;
  int          msg_done = 0;
  logic [31:0] expq[$];
  bit          raw[$];
  bit          exp_s[$];
  logic [15:0] diag_exp;
  int          match_at = 0;

  report_link_if report_link_if_inst ();
  report_tx_framer report_tx_framer_inst (.clk, .sys_rst, .ce(1'b1), .diag_mode,
    .link(report_link_if_inst), .report_pending, .data_check_select, .check_word_enable,
    .shift_load_select, .stuff_skip_n, .buffer_write_strobe);
  report_ctl_end report_ctl_end_inst (.clk, .sys_rst, .ce(1'b1), .addr, .wdata, .wr, .rd,
    .rdata, .diag_mode, .link(report_link_if_inst));
  report_link_asserts report_link_asserts_inst (.clk, .sys_rst,
    .cmd(report_link_if_inst.cmd), .diag_valid(report_link_if_inst.diag_valid),
    .tx_line(report_link_if_inst.tx_line), .tx_clock(report_link_if_inst.tx_clock),
    .gated_tx_clock(report_link_if_inst.gated_tx_clock),
    .message_idle_select(report_link_if_inst.message_idle_select), .diag_mode,
    .report_pending, .data_check_select, .check_word_enable, .shift_load_select,
    .stuff_skip_n, .buffer_write_strobe);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task final_report;
    if (n_errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report

  task bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : bus_wr

  // Expected read data is noted here and compared by the monitor two cycles later
  task bus_rd(input logic [7:0] a, input logic c, input logic [31:0] e);
    @(posedge clk);
    addr  <= a;
    rd    <= 1'b1;
    chk_q <= c;
    if (c) expq.push_back(e);
    @(posedge clk);
    rd    <= 1'b0;
    chk_q <= 1'b0;
  endtask : bus_rd

  // Stuffed pattern is searched, so idle bits around it need no alignment
  function automatic bit found();
    int k;
    for (int s = 0; s + exp_s.size() <= raw.size(); s++) begin
      for (k = 0; k < exp_s.size() && raw[s+k] == exp_s[k]; k++) ;
      if (k == exp_s.size()) begin
        match_at = s;
        return 1'b1;
      end
    end
    match_at = 0;
    return 1'b0;
  endfunction : found

  // Receiver view: drop the zero after five ones; data plus check leaves no remainder
  function automatic logic [15:0] strip_crc();
    logic [15:0] c;
    int          ones;
    c = 16'h0000;
    ones = 0;
    for (int i = match_at; i < match_at + exp_s.size() && i < raw.size(); i++) begin
      if (ones == 5) ones = 0;
      else begin
        c = {c[14:0], 1'b0} ^ ((c[15] ^ raw[i]) ? CRC_POLY : 16'h0000);
        ones = raw[i] ? ones + 1 : 0;
      end
    end
    return c;
  endfunction : strip_crc

  always @(posedge clk) begin
    chk_d_q <= chk_q;
    tx_p_q  <= report_link_if_inst.tx_clock;
    ms_p_q  <= report_link_if_inst.message_idle_select;
    if (chk_d_q) check(rdata, expq.pop_front());
    if (report_link_if_inst.tx_clock && !tx_p_q) raw.push_back(report_link_if_inst.tx_line);
    // Loopback word is the last sixteen line bits when the read command is decoded
    if (report_link_if_inst.cmd == make_cmd(OP_DIAG_READ) && raw.size() >= 16)
      for (int i = 0; i < 16; i++) diag_exp[i] = raw[raw.size() - 1 - i];
    if (ms_p_q && !report_link_if_inst.message_idle_select) begin
      check(32'(found()), 32'h1);
      check({16'h0000, strip_crc()}, 32'h0);
      msg_done++;
    end
  end

  task send_msg(input int n);
    logic [15:0] w, crc;
    int          ones, d0;
    crc = 16'h0000;
    ones = 0;
    exp_s.delete();
    for (int i = 0; i <= n; i++) begin
      w = (i == n) ? crc : (i == 0) ? 16'hFFFF : 16'($urandom);
      if (i < n) bus_wr(OFS_WORD, {16'h0000, w});
      for (int b = 15; b >= 0; b--) begin
        if (i < n) crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ w[b]) ? CRC_POLY : 16'h0000);
        exp_s.push_back(w[b]);
        ones = w[b] ? ones + 1 : 0;
        if (ones == 5) begin
          exp_s.push_back(1'b0);
          ones = 0;
        end
      end
    end
    if (n == 16) begin
      bus_wr(OFS_WORD, 32'h0000_1234);
      bus_rd(OFS_STATUS, 1'b1, 32'h0000_0010);
    end
    d0 = msg_done;
    raw.delete();
    bus_wr(OFS_CTRL, 32'h0000_0001);
    for (int t = 0; t < 9000 && msg_done == d0; t++) @(posedge clk);
    @(posedge clk);
    check(32'(report_pending), 32'h0);
    bus_rd(OFS_STATUS, 1'b1, 32'h0);
  endtask : send_msg

  initial begin
    #(40 * 60000);
    n_errors++;
    final_report();
  end

  initial begin
    logic [7:0] v;
    void'($urandom(5));
    sys_rst = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    chk_q = 1'b0;
    repeat (16) @(posedge clk);
    check(32'({report_pending, shift_load_select, stuff_skip_n, data_check_select,
               report_link_if_inst.message_idle_select, report_link_if_inst.tx_line}),
          32'h1D);
    sys_rst <= 1'b0;
    bus_rd(OFS_STATUS, 1'b1, 32'h0);
    bus_rd(8'h20, 1'b1, 32'h0);
    bus_wr(OFS_CTRL, 32'h0000_0001);
    bus_rd(OFS_STATUS, 1'b1, 32'h0);
    // End bits kept zero so idle never lengthens a run of ones at message edges
    v = {1'b0, 6'($urandom), 1'b0};
    bus_wr(OFS_IDLE, {24'h0, v});
    for (int t = 0; t < 200 && shift_load_select !== 1'b0; t++) @(posedge clk);
    for (int t = 0; t < 20 && shift_load_select !== 1'b1; t++) @(posedge clk);
    raw.delete();
    exp_s.delete();
    for (int b = 7; b >= 0; b--) exp_s.push_back(v[b]);
    repeat (140) @(posedge clk);
    check(32'(found()), 32'h1);
    send_msg(1);
    send_msg(16);
    send_msg(2 + $urandom_range(13));
    bus_wr(OFS_CTRL, 32'h0000_0004);
    bus_wr(OFS_CTRL, 32'h0000_0002);
    bus_rd(OFS_CTRL, 1'b1, 32'h0000_0002);
    bus_wr(OFS_CTRL, 32'h0000_0006);
    repeat (2) @(posedge clk);
    bus_rd(OFS_DIAG, 1'b1, {16'h0000, diag_exp});
    bus_wr(OFS_CTRL, 32'h0);
    repeat (4) @(posedge clk);
    final_report();
  end
endmodule : report_link_tx_framing_tb_top
